/* File: core/scbr_regs.v */
`timescale 1ns/1ns
`include "scbr_map.vh"

module scbr_regs (
    input  wire        sys_clk_i,
    input  wire        rst_i,
    // APB slave
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    input  wire [3:0]  pstrb_i,
    output reg  [31:0] prdata_o,
    output wire        pready_o,
    output wire        pslverr_o,
    // Core status, same clock
    input  wire        core_wfe_sleep_i,
    input  wire        wfe_exec_i,
    input  wire        send_event_instr_i,
    input  wire        irq_enabled_pend_i,
    input  wire        irq_any_new_pend_i,
    input  wire        event_enabled_i,
    input  wire        handler_last_exit_i,
    input  wire        exc_entry_i,
    input  wire        sp_bit2_i,
    input  wire        exception_return_code_i,
    input  wire        stacked_pad_i,
    input  wire        handler_prio_neg_i,
    input  wire        data_busfault_i,
    input  wire        div_exec_i,
    input  wire        div_zero_i,
    input  wire        unaligned_single_i,
    input  wire        unaligned_multi_i,
    input  wire        trig_write_i,
    input  wire        trig_privileged_i,
    input  wire        thread_return_i,
    input  wire        other_active_i,
    // External event pin
    input  wire        ext_event_i,
    // Outputs to core and system
    output reg         system_reset_request_o,
    output wire        wake_o,
    output wire        deep_sleep_o,
    output wire        sleep_o,
    output wire        stack_pad_o,
    output wire        psr_pad_flag_o,
    output wire        sp_restore_add4_o,
    output wire        busfault_ignore_o,
    output wire        lockup_o,
    output wire        div_trap_o,
    output wire        div_quot_zero_o,
    output wire        usage_fault_unaligned_o,
    output wire        trig_write_accept_o,
    output wire        thread_return_fault_o,
    output wire [31:0] prio_fields_o
);

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    reg        wake_on_any_pending;
    reg        deep_sleep_select;
    reg        sleep_on_handler_exit;
    reg        stack_align_select;
    reg        high_prio_busfault_ignore;
    reg        divide_zero_trap;
    reg        unaligned_access_trap;
    reg        unprivileged_trigger_enable;
    reg        thread_entry_any_level;
    reg [3:0]  prio_hi [0:4];
    reg        event_latch;
    reg        ext_meta;
    reg        ext_sync;
    reg        ext_prev;

    wire       wr_acc   = psel_i & penable_i & pwrite_i;
    // Read word is taken in setup so it is already a flop output in access
    wire       rd_setup = psel_i & ~penable_i & ~pwrite_i;

    // One-hot register select, shared by the write and read paths
    function [5:0] scbr_reg_sel;
        input [11:0] addr;
        begin
            scbr_reg_sel = 6'h00;
            if (addr == `SCBR_OFF_RESET_CTRL) begin
                scbr_reg_sel = 6'h01;
            end else if (addr == `SCBR_OFF_SYS_CTRL) begin
                scbr_reg_sel = 6'h02;
            end else if (addr == `SCBR_OFF_CFG_CTRL) begin
                scbr_reg_sel = 6'h04;
            end else if (addr == `SCBR_OFF_PRIO_ONE) begin
                scbr_reg_sel = 6'h08;
            end else if (addr == `SCBR_OFF_PRIO_TWO) begin
                scbr_reg_sel = 6'h10;
            end else if (addr == `SCBR_OFF_PRIO_THREE) begin
                scbr_reg_sel = 6'h20;
            end
        end
    endfunction

    wire [5:0] reg_sel = scbr_reg_sel(paddr_i);

    // Byte lane to priority slot; 7 means no slot
    function [2:0] scbr_slot;
        input [11:0] addr;
        input [1:0]  lane;
        begin
            scbr_slot = 3'h7;
            if (addr == `SCBR_OFF_PRIO_ONE && lane != 2'h3) begin
                scbr_slot = {1'b0, lane};
            end else if (addr == `SCBR_OFF_PRIO_TWO && lane == 2'h3) begin
                scbr_slot = 3'h3;
            end else if (addr == `SCBR_OFF_PRIO_THREE && lane == 2'h2) begin
                scbr_slot = 3'h4;
            end else if (addr == `SCBR_OFF_PRIO_THREE && lane == 2'h3) begin
                scbr_slot = 3'h5;
            end
        end
    endfunction

    // Zero wait states; unmapped reads give zero, no error
    assign pready_o  = 1'b1;
    assign pslverr_o = 1'b0;

    // ----------------------------------------
    // Priority bytes, byte-lane writable
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : lane_g
            // Lanes 0-2 of register one map one to one onto slots 0-2
            localparam integer LANE_N = g;
            localparam [1:0]   LANE   = LANE_N[1:0];
            localparam [2:0]   SLOT   = LANE_N[2:0];
            wire [2:0] s = scbr_slot(paddr_i, LANE);
            always @(posedge sys_clk_i) begin
                if (rst_i) begin
                    prio_hi[g] <= `SCBR_RST_PRIO;
                end else if (wr_acc && pstrb_i[g] && s == SLOT) begin
                    prio_hi[g] <= pwdata_i[8*LANE_N+7 -: 4];
                end
            end
        end
    endgenerate

    // Slot 3 is lane 3 of register two, slot 4/5 lanes 2/3 of register three
    wire [2:0] slot2 = scbr_slot(paddr_i, 2'h2);
    wire [2:0] slot3 = scbr_slot(paddr_i, 2'h3);
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            prio_hi[3] <= `SCBR_RST_PRIO;
            prio_hi[4] <= `SCBR_RST_PRIO;
        end else if (wr_acc) begin
            if (pstrb_i[3] && slot3 == 3'h3) prio_hi[3] <= pwdata_i[31:28];
            if (pstrb_i[2] && slot2 == 3'h4) prio_hi[4] <= pwdata_i[23:20];
        end
    end

    reg [3:0] prio_tick;
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            prio_tick <= `SCBR_RST_PRIO;
        end else if (wr_acc && pstrb_i[3] && slot3 == 3'h5) begin
            prio_tick <= pwdata_i[31:28];
        end
    end

    // ----------------------------------------
    // Control bits and reset request
    // ----------------------------------------
    wire key_ok = pwdata_i[31:16] == `SCBR_KEY_VALUE;
    wire full_w = pstrb_i == 4'hf;

    // ----------------------------------------
    // Write strobes per register
    // ----------------------------------------
    // Control words take whole-word writes only; a partial write is dropped
    wire wr_full  = wr_acc & full_w;
    wire we_reset = wr_full & reg_sel[0] & key_ok;
    wire we_sys   = wr_full & reg_sel[1];
    wire we_cfg   = wr_full & reg_sel[2];

    // Sticky until system reset clears it; kept apart from any debug reset
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            system_reset_request_o <= `SCBR_RST_BIT;
        end else if (we_reset && pwdata_i[`SCBR_BIT_RESET_REQ]) begin
            // Debug bits [1:0] are never acted on
            system_reset_request_o <= 1'b1;
        end
    end

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            wake_on_any_pending   <= `SCBR_RST_BIT;
            deep_sleep_select     <= `SCBR_RST_BIT;
            sleep_on_handler_exit <= `SCBR_RST_BIT;
        end else if (we_sys) begin
            wake_on_any_pending   <= pwdata_i[`SCBR_BIT_WAKE_PEND];
            deep_sleep_select     <= pwdata_i[`SCBR_BIT_DEEP_SLEEP];
            sleep_on_handler_exit <= pwdata_i[`SCBR_BIT_SLEEP_EXIT];
        end
    end

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            stack_align_select          <= `SCBR_RST_BIT;
            high_prio_busfault_ignore   <= `SCBR_RST_BIT;
            divide_zero_trap            <= `SCBR_RST_BIT;
            unaligned_access_trap       <= `SCBR_RST_BIT;
            unprivileged_trigger_enable <= `SCBR_RST_BIT;
            thread_entry_any_level      <= `SCBR_RST_BIT;
        end else if (we_cfg) begin
            stack_align_select          <= pwdata_i[`SCBR_BIT_STACK_ALIGN];
            high_prio_busfault_ignore   <= pwdata_i[`SCBR_BIT_BUSF_IGNORE];
            divide_zero_trap            <= pwdata_i[`SCBR_BIT_DIV_TRAP];
            unaligned_access_trap       <= pwdata_i[`SCBR_BIT_UNALIGN_TRAP];
            unprivileged_trigger_enable <= pwdata_i[`SCBR_BIT_UNPRIV_TRIG];
            thread_entry_any_level      <= pwdata_i[`SCBR_BIT_THREAD_ANY];
        end
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    wire [31:0] prio_one_word   = {8'h00, prio_hi[2], 4'h0, prio_hi[1], 4'h0, prio_hi[0], 4'h0};
    wire [31:0] prio_two_word   = {prio_hi[3], 4'h0, 24'h00_0000};
    wire [31:0] prio_three_word = {prio_tick, 4'h0, prio_hi[4], 4'h0, 16'h0000};

    reg [31:0] next_rdata;
    always @* begin
        next_rdata = 32'h0000_0000;
        if (reg_sel[0]) begin
            next_rdata = 32'h0000_0000;
        end else if (reg_sel[1]) begin
            next_rdata[`SCBR_BIT_WAKE_PEND]  = wake_on_any_pending;
            next_rdata[`SCBR_BIT_DEEP_SLEEP] = deep_sleep_select;
            next_rdata[`SCBR_BIT_SLEEP_EXIT] = sleep_on_handler_exit;
        end else if (reg_sel[2]) begin
            next_rdata[`SCBR_BIT_STACK_ALIGN]  = stack_align_select;
            next_rdata[`SCBR_BIT_BUSF_IGNORE]  = high_prio_busfault_ignore;
            next_rdata[`SCBR_BIT_DIV_TRAP]     = divide_zero_trap;
            next_rdata[`SCBR_BIT_UNALIGN_TRAP] = unaligned_access_trap;
            next_rdata[`SCBR_BIT_UNPRIV_TRIG]  = unprivileged_trigger_enable;
            next_rdata[`SCBR_BIT_THREAD_ANY]   = thread_entry_any_level;
        end else if (reg_sel[3]) begin
            next_rdata = prio_one_word;
        end else if (reg_sel[4]) begin
            next_rdata = prio_two_word;
        end else if (reg_sel[5]) begin
            next_rdata = prio_three_word;
        end
    end

    // Read data registered; stable from the access edge onward
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_o <= next_rdata;
        end
    end

    // ----------------------------------------
    // Wake logic
    // ----------------------------------------
    // External pin is asynchronous: two flops before use
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_meta <= ext_event_i;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    wire ext_rise   = ext_sync & ~ext_prev;
    wire wake_en    = event_enabled_i | irq_enabled_pend_i;
    wire wake_pend  = wake_on_any_pending & irq_any_new_pend_i;
    wire wake_instr = send_event_instr_i | ext_rise;
    wire wake_src   = wake_en | wake_pend | wake_instr;

    // Latch holds an event seen while not sleeping; consumed by next wait
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            event_latch <= 1'b0;
        end else if (wake_src && !core_wfe_sleep_i) begin
            event_latch <= 1'b1;
        end else if (wfe_exec_i || core_wfe_sleep_i) begin
            event_latch <= 1'b0;
        end
    end

    // Combinational so a wait returns the same cycle it finds the latch set
    assign wake_o = (core_wfe_sleep_i | wfe_exec_i) & (wake_src | event_latch);

    // ----------------------------------------
    // Core control outputs
    // ----------------------------------------
    assign deep_sleep_o  = deep_sleep_select;
    assign sleep_o       = handler_last_exit_i & sleep_on_handler_exit;
    // Pad only when 8-byte alignment chosen and SP sits on a 4-byte boundary
    assign stack_pad_o    = exc_entry_i & stack_align_select & sp_bit2_i;
    assign psr_pad_flag_o = stack_pad_o;
    assign sp_restore_add4_o = exception_return_code_i & stacked_pad_i;
    assign busfault_ignore_o = data_busfault_i & handler_prio_neg_i & high_prio_busfault_ignore;
    assign lockup_o          = data_busfault_i & handler_prio_neg_i & ~high_prio_busfault_ignore;
    assign div_trap_o        = div_exec_i & div_zero_i & divide_zero_trap;
    assign div_quot_zero_o   = div_exec_i & div_zero_i & ~divide_zero_trap;
    assign usage_fault_unaligned_o = (unaligned_single_i & unaligned_access_trap)
                                   | unaligned_multi_i;
    assign trig_write_accept_o = trig_write_i & (trig_privileged_i | unprivileged_trigger_enable);
    assign thread_return_fault_o = thread_return_i & other_active_i & ~thread_entry_any_level;
    assign prio_fields_o = {prio_tick, prio_hi[4], prio_hi[3], prio_hi[2], prio_hi[1], prio_hi[0], 8'h00};

endmodule

/* File: shared/scbr_map.vh */
`ifndef SCBR_MAP_VH
`define SCBR_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SCBR_OFF_RESET_CTRL 12'h00c
`define SCBR_OFF_SYS_CTRL   12'h010
`define SCBR_OFF_CFG_CTRL   12'h014
`define SCBR_OFF_PRIO_ONE   12'h018
`define SCBR_OFF_PRIO_TWO   12'h01c
`define SCBR_OFF_PRIO_THREE 12'h020

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCBR_BIT_RESET_REQ    2
`define SCBR_KEY_VALUE        16'h05fa
`define SCBR_BIT_WAKE_PEND    4
`define SCBR_BIT_DEEP_SLEEP   2
`define SCBR_BIT_SLEEP_EXIT   1
`define SCBR_BIT_STACK_ALIGN  9
`define SCBR_BIT_BUSF_IGNORE  8
`define SCBR_BIT_DIV_TRAP     4
`define SCBR_BIT_UNALIGN_TRAP 3
`define SCBR_BIT_UNPRIV_TRIG  1
`define SCBR_BIT_THREAD_ANY   0
`define SCBR_PSR_PAD_BIT      9

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SCBR_RST_PRIO 4'h0
`define SCBR_RST_BIT  1'b0

`endif

/* File: verif/scbr_core_model.sv */
`timescale 1ns/1ns

module scbr_core_model (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic wfe_req_i,
    input  wire logic wake_i,
    output logic      wfe_exec_o,
    output logic      core_wfe_sleep_o
);
    // --------------
    // Sleep state
    // --------------
    // A wake seen during the instruction cycle keeps the core running
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            wfe_exec_o       <= 1'b0;
            core_wfe_sleep_o <= 1'b0;
        end else begin
            wfe_exec_o <= wfe_req_i;
            if (wake_i)
                core_wfe_sleep_o <= 1'b0;
            else if (wfe_exec_o)
                core_wfe_sleep_o <= 1'b1;
        end
    end
endmodule

/* File: verif/scbr_regs_bench.sv */
`timescale 1ns/1ns

module scbr_regs_bench;
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] d;
        logic [3:0]  s;
        logic [31:0] e;
    } scbr_row_t;

    logic        sys_clk_i, rst_i, psel_i, penable_i, pwrite_i, wfe_req, core_wfe_sleep_i, wfe_exec_i, b;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, prio_fields_o, rd;
    logic [3:0]  pstrb_i;
    logic [12:0] core_q;
    logic        send_event_instr_i, irq_enabled_pend_i, irq_any_new_pend_i, event_enabled_i, ext_event_i;
    logic        handler_last_exit_i, exc_entry_i, sp_bit2_i, exception_return_code_i, stacked_pad_i, handler_prio_neg_i;
    logic        data_busfault_i, div_exec_i, div_zero_i, unaligned_single_i, unaligned_multi_i, trig_write_i;
    logic        trig_privileged_i, thread_return_i, other_active_i, pready_o, pslverr_o, wake_o, lockup_o;
    logic        system_reset_request_o, deep_sleep_o, sleep_o, stack_pad_o, psr_pad_flag_o, sp_restore_add4_o;
    logic        busfault_ignore_o, div_trap_o, div_quot_zero_o, usage_fault_unaligned_o;
    logic        trig_write_accept_o, thread_return_fault_o, err;
    int          fail_count = 0, num_checks = 0, cycles = 0;
    scbr_row_t   rows [8];

    assign {div_exec_i, div_zero_i, unaligned_single_i, handler_prio_neg_i, data_busfault_i, trig_write_i,
            thread_return_i, other_active_i, exc_entry_i, sp_bit2_i, exception_return_code_i, stacked_pad_i,
            handler_last_exit_i} = core_q;

    scbr_regs scbr_regs_i (.*);
    scbr_core_model scbr_core_model_i (
        .sys_clk_i        (sys_clk_i),
        .rst_i            (rst_i),
        .wfe_req_i        (wfe_req),
        .wake_i           (wake_o),
        .wfe_exec_o       (wfe_exec_i),
        .core_wfe_sleep_o (core_wfe_sleep_i)
    );

    // --------------
    // Clock, timeout
    // --------------
    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            stop_test();
        end
    end

    // --------------
    // Tasks
    // --------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Trailing edge keeps the next setup out of this release step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        pstrb_i <= s;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        @(posedge sys_clk_i);
        while (pready_o !== 1'b1) @(posedge sys_clk_i);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    task automatic wait_for_event_instr();
        wfe_req <= 1'b1;
        @(posedge sys_clk_i);
        wfe_req <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
    endtask
    // 0 new pending, 1 enabled pending, 2 send event, 3 enabled event
    task automatic pulse(input int which);
        case (which)
            0: irq_any_new_pend_i <= 1'b1;
            1: irq_enabled_pend_i <= 1'b1;
            2: send_event_instr_i <= 1'b1;
            default: event_enabled_i <= 1'b1;
        endcase
        @(posedge sys_clk_i);
        {irq_any_new_pend_i, irq_enabled_pend_i, send_event_instr_i, event_enabled_i} <= 4'h0;
    endtask

    // --------------
    // Sequence
    // --------------
    initial begin
        rows = '{'{12'h010, 32'h16, 4'hf, 32'h16}, '{12'h010, 32'h0, 4'h1, 32'h16},
                 '{12'h014, 32'h31b, 4'hf, 32'h31b}, '{12'h018, 32'hffffffff, 4'hf, 32'h00f0f0f0},
                 '{12'h018, 32'h5a00, 4'h2, 32'h00f050f0}, '{12'h01c, 32'hffffffff, 4'hf, 32'hf0000000},
                 '{12'h020, 32'hffffffff, 4'hf, 32'hf0f00000}, '{12'h100, 32'hffffffff, 4'hf, 32'h0}};
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, pstrb_i, core_q, wfe_req} = '0;
        {send_event_instr_i, irq_enabled_pend_i, irq_any_new_pend_i, event_enabled_i} = '0;
        {ext_event_i, unaligned_multi_i, trig_privileged_i} = '0;
        rst_i = 1'b1;
        repeat (3) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            apb(1'b0, rows[i].a, 32'h0, 4'hf);
            check(rd, 32'h0);
        end
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d, rows[i].s);
            apb(1'b0, rows[i].a, 32'h0, 4'hf);
            check(rd, rows[i].e);
            check(err, 1'b0);
        end
        check(prio_fields_o, 32'hffff5f00);
        apb(1'b1, 12'h00c, 32'h4, 4'hf);
        check(system_reset_request_o, 1'b0);
        apb(1'b1, 12'h00c, 32'h05fa0004, 4'hf);
        check(system_reset_request_o, 1'b1);
        apb(1'b0, 12'h00c, 32'h0, 4'hf);
        check(rd[2:0], 3'h0);
        rst_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        check(system_reset_request_o, 1'b0);
        check(prio_fields_o, 32'h0);
        for (int k = 1; k >= 0; k--) begin
            b = k[0];
            apb(1'b1, 12'h014, k ? 32'h31b : 32'h0, 4'hf);
            apb(1'b1, 12'h010, k ? 32'h16 : 32'h0, 4'hf);
            core_q <= '1;
            @(negedge sys_clk_i);
            check({div_trap_o, div_quot_zero_o}, {b, !b});
            check({usage_fault_unaligned_o, trig_write_accept_o}, {b, b});
            check({busfault_ignore_o, lockup_o, thread_return_fault_o}, {b, !b, !b});
            check({stack_pad_o, psr_pad_flag_o, sp_restore_add4_o}, {b, b, 1'b1});
            check({sleep_o, deep_sleep_o}, {b, b});
            @(posedge sys_clk_i);
            core_q <= 13'h0080;
            {unaligned_multi_i, trig_privileged_i} <= 2'h3;
            @(negedge sys_clk_i);
            check(usage_fault_unaligned_o, 1'b1);
            check(trig_write_accept_o, 1'b1);
            @(posedge sys_clk_i);
            core_q <= '0;
            {unaligned_multi_i, trig_privileged_i} <= 2'h0;
            wait_for_event_instr();
            pulse(0);
            repeat (2) @(posedge sys_clk_i);
            check(core_wfe_sleep_i, !b);
        end
        pulse(1);
        @(posedge sys_clk_i);
        check(core_wfe_sleep_i, 1'b0);
        wait_for_event_instr();
        pulse(2);
        @(posedge sys_clk_i);
        check(core_wfe_sleep_i, 1'b0);
        pulse(2);
        wait_for_event_instr();
        check(core_wfe_sleep_i, 1'b0);
        wait_for_event_instr();
        check(core_wfe_sleep_i, 1'b1);
        ext_event_i <= 1'b1;
        repeat (7) @(posedge sys_clk_i);
        check(core_wfe_sleep_i, 1'b0);
        ext_event_i <= 1'b0;
        wait_for_event_instr();
        check(core_wfe_sleep_i, 1'b1);
        pulse(3);
        @(posedge sys_clk_i);
        check(core_wfe_sleep_i, 1'b0);
        stop_test();
    end
endmodule

/* File: verif/scbr_regs_checker.sv */
`timescale 1ns/1ns
`include "scbr_map.vh"

module scbr_regs_checker (
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0]  pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic [31:0] prio_fields_o,
    input wire logic        system_reset_request_o,
    input wire logic        core_wfe_sleep_i,
    input wire logic        send_event_instr_i,
    input wire logic        wake_o,
    input wire logic        div_exec_i,
    input wire logic        div_zero_i,
    input wire logic        div_trap_o,
    input wire logic        div_quot_zero_o,
    input wire logic        unaligned_multi_i,
    input wire logic        usage_fault_unaligned_o
);
    // --------------
    // Helper logic
    // --------------
    // Write data of the previous cycle, compared once the write has landed
    logic [31:0] last_wdata;
    always @(posedge sys_clk_i) last_wdata <= pwdata_i;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_ctrl_write;
        psel_i && penable_i && pwrite_i && paddr_i == `SCBR_OFF_RESET_CTRL && pstrb_i == 4'hf;
    endsequence
    sequence s_keyed;
        s_ctrl_write ##0 pwdata_i[31:16] == `SCBR_KEY_VALUE;
    endsequence

    // --------------
    // Assertions
    // --------------
    AST_REQ_KEYED: assert property (s_keyed ##0 pwdata_i[`SCBR_BIT_RESET_REQ] |=> system_reset_request_o)
        else $error("keyed write did not raise the reset request");
    AST_REQ_NO_KEY: assert property (s_ctrl_write ##0 pwdata_i[31:16] != `SCBR_KEY_VALUE ##0
        !system_reset_request_o |=> !system_reset_request_o)
        else $error("write without key changed the reset request");
    AST_REQ_HOLD: assert property (system_reset_request_o |=> system_reset_request_o)
        else $error("reset request dropped without reset");
    AST_CTRL_RD_LOW: assert property (psel_i && penable_i && !pwrite_i &&
        paddr_i == `SCBR_OFF_RESET_CTRL |-> prdata_o[2:0] == 3'h0)
        else $error("request or debug bits read nonzero");
    AST_PRIO_ONE: assert property (psel_i && penable_i && pwrite_i && paddr_i == `SCBR_OFF_PRIO_ONE &&
        pstrb_i == 4'hf |=> prio_fields_o[19:0] == {last_wdata[23:20], last_wdata[15:12], last_wdata[7:4], 8'h00})
        else $error("first priority fields do not follow the write");
    AST_SEV_WAKE: assert property (core_wfe_sleep_i && send_event_instr_i |-> wake_o)
        else $error("send event did not wake the core");
    AST_DIV_ZERO: assert property (div_exec_i && div_zero_i |-> div_trap_o != div_quot_zero_o)
        else $error("divide by zero neither trapped nor zeroed");
    AST_MULTI_FAULT: assert property (unaligned_multi_i |-> usage_fault_unaligned_o)
        else $error("unaligned multiple access did not fault");
endmodule

bind scbr_regs scbr_regs_checker scbr_regs_checker_i (.*);
